// [design/adc_out_pkg.sv]
// Constants, field layouts and state records for the dual converter output control
package adc_out_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int WORD_W = 10;
  localparam int GAIN_W = 5;
  localparam int COUNT_W = 16;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] GAIN_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] COUNT_OFS = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_DUAL_BIT = 0;
  localparam int CTRL_AONLY_BIT = 1;
  localparam int CTRL_RATE80_BIT = 2;
  localparam int GAIN_A_LSB = 0;
  localparam int GAIN_B_LSB = 8;
  localparam int STAT_PDWN_BIT = 0;
  localparam int STAT_DRIVE_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values and gain scale
  // ----------------------------------------------------------------
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [4:0] GAIN_RESET = 5'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam int GAIN_STEPS = 31;
  localparam int GAIN_STEP_UDB = 582600;

  // ----------------------------------------------------------------
  // State records
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rate80;
    logic aOnly;
    logic dualBus;
  } outMode_t;

  typedef struct packed {
    outMode_t mode;
    logic [GAIN_W-1:0] gainA;
    logic [GAIN_W-1:0] gainB;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic driveMeta;
    logic driveSync;
    logic pdMeta;
    logic pdSync;
    logic tglMeta;
    logic tglSync;
    logic tglSeen;
    logic [COUNT_W-1:0] sampleCount;
  } busState_t;

  typedef struct packed {
    outMode_t modeMeta;
    outMode_t modeSync;
    logic oeMeta;
    logic oeSync;
    logic pdMeta;
    logic pdSync;
    logic phase;
    logic [WORD_W-1:0] holdB;
    logic [WORD_W-1:0] primary;
    logic primaryOe;
    logic [WORD_W-1:0] second;
    logic secondOe;
    logic latch;
    logic latchInv;
    logic latchOe;
    logic drive;
    logic sampleTgl;
  } linkState_t;

endpackage

// [design/dual_adc_output_bus_control.sv]
// Output bus control of a dual 10-bit converter with APB configuration
//
// Summary of operation
// - Each sample leaves the primary bus as a 10-bit word, bit 9 most significant.
// - Primary bus carries both channels or channel A alone, per output mode.
// - In dual-bus mode channel B words leave on the second bus.
// - Second bus floats while powered down or in single-bus mode.
// - Primary bus floats while powered down.
// - Buses and both latch clocks drive only while output enable is low.
// - A latch clock accompanies the data words for the receiver.
// - An inverted latch clock is also given; both float during power-down.
// - At 40MHz converter clock the inputs are sampled on every rising edge, or on every second edge when interleaving.
// - At 80MHz converter clock the inputs are sampled on every second edge.
// - Each channel's gain comes from its own 5-bit code.
// - Gain spans 31 equal steps of 0.5826dB, unity to about 18dB.
`timescale 1ns/1ps
module dual_adc_output_bus_control
  import adc_out_pkg::*;
(
  // Register clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // Converter clock and core samples
  input wire logic convClk,
  input wire logic [WORD_W-1:0] sampleA,
  input wire logic [WORD_W-1:0] sampleB,
  // Control pins
  input wire logic outputEnable_n,
  input wire logic powerDown,
  // Gain codes to the amplifiers
  output logic [GAIN_W-1:0] gainCodeA,
  output logic [GAIN_W-1:0] gainCodeB,
  // Output pins
  output logic [WORD_W-1:0] primary_bus_data,
  output logic primaryBusOe,
  output logic [WORD_W-1:0] second_bus_data,
  output logic secondBusOe,
  output logic output_latch_clock,
  output logic outputLatchClockInv,
  output logic latchClockOe
);

  busState_t b_r;
  busState_t b_nxt;
  linkState_t l_r;
  linkState_t l_nxt;
  logic setup;
  logic access;
  logic interleave;
  logic capture;

  // ----------------------------------------------------------------
  // Register domain
  // ----------------------------------------------------------------
  assign setup = psel && !penable && !b_r.pready;
  assign access = psel && penable && b_r.pready;

  always_comb begin
    b_nxt = b_r;
    b_nxt.pready = 1'b0;
    b_nxt.pslverr = 1'b0;
    // Levels and the sample toggle from the converter side
    b_nxt.driveMeta = l_r.drive;
    b_nxt.driveSync = b_r.driveMeta;
    b_nxt.pdMeta = l_r.pdSync;
    b_nxt.pdSync = b_r.pdMeta;
    b_nxt.tglMeta = l_r.sampleTgl;
    b_nxt.tglSync = b_r.tglMeta;
    b_nxt.tglSeen = b_r.tglSync;
    if (b_r.tglSync != b_r.tglSeen) begin
      b_nxt.sampleCount = b_r.sampleCount + 16'h0001;
    end
    // Answer is prepared in the setup cycle, given in the access cycle
    if (setup) begin
      b_nxt.pready = 1'b1;
      b_nxt.prdata = 32'h0;
      if (paddr == CTRL_OFS) begin
        b_nxt.prdata[CTRL_DUAL_BIT] = b_r.mode.dualBus;
        b_nxt.prdata[CTRL_AONLY_BIT] = b_r.mode.aOnly;
        b_nxt.prdata[CTRL_RATE80_BIT] = b_r.mode.rate80;
      end else if (paddr == GAIN_OFS) begin
        b_nxt.prdata[GAIN_A_LSB +: GAIN_W] = b_r.gainA;
        b_nxt.prdata[GAIN_B_LSB +: GAIN_W] = b_r.gainB;
      end else if (paddr == STATUS_OFS) begin
        b_nxt.prdata[STAT_PDWN_BIT] = b_r.pdSync;
        b_nxt.prdata[STAT_DRIVE_BIT] = b_r.driveSync;
      end else if (paddr == COUNT_OFS) begin
        b_nxt.prdata[COUNT_W-1:0] = b_r.sampleCount;
      end else begin
        b_nxt.pslverr = 1'b1;
      end
    end
    if (access && pwrite && !b_r.pslverr) begin
      if (paddr == CTRL_OFS) begin
        b_nxt.mode.dualBus = pwdata[CTRL_DUAL_BIT];
        b_nxt.mode.aOnly = pwdata[CTRL_AONLY_BIT];
        b_nxt.mode.rate80 = pwdata[CTRL_RATE80_BIT];
      end else if (paddr == GAIN_OFS) begin
        // Code n selects n steps above unity, up to the top step
        b_nxt.gainA = pwdata[GAIN_A_LSB +: GAIN_W];
        b_nxt.gainB = pwdata[GAIN_B_LSB +: GAIN_W];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      b_r <= '0;
      b_r.mode <= outMode_t'(CTRL_RESET);
      b_r.gainA <= GAIN_RESET;
      b_r.gainB <= GAIN_RESET;
      b_r.sampleCount <= COUNT_RESET;
    end else begin
      b_r <= b_nxt;
    end
  end

  assign pready = b_r.pready;
  assign pslverr = b_r.pslverr;
  assign prdata = b_r.prdata;
  assign gainCodeA = b_r.gainA;
  assign gainCodeB = b_r.gainB;

  // ----------------------------------------------------------------
  // Converter clock domain
  // ----------------------------------------------------------------
  assign interleave = !l_r.modeSync.dualBus && !l_r.modeSync.aOnly;
  // Interleaving and 80MHz both take a pair only on the first phase
  assign capture = (interleave || l_r.modeSync.rate80) ? !l_r.phase : 1'b1;

  always_comb begin
    l_nxt = l_r;
    l_nxt.modeMeta = b_r.mode;
    l_nxt.modeSync = l_r.modeMeta;
    l_nxt.oeMeta = outputEnable_n;
    l_nxt.oeSync = l_r.oeMeta;
    l_nxt.pdMeta = powerDown;
    l_nxt.pdSync = l_r.pdMeta;
    l_nxt.phase = !l_r.phase;
    l_nxt.drive = !l_r.oeSync && !l_r.pdSync;
    l_nxt.primaryOe = !l_r.oeSync && !l_r.pdSync;
    l_nxt.secondOe = !l_r.oeSync && !l_r.pdSync && l_r.modeSync.dualBus;
    l_nxt.latchOe = !l_r.oeSync && !l_r.pdSync;
    // When interleaving, latch high with an A word, low with a B word
    l_nxt.latch = !l_r.phase;
    l_nxt.latchInv = l_r.phase;
    if (capture) begin
      l_nxt.primary = sampleA;
      l_nxt.second = sampleB;
      l_nxt.holdB = sampleB;
      l_nxt.sampleTgl = !l_r.sampleTgl;
    end else if (interleave) begin
      l_nxt.primary = l_r.holdB;
    end
  end

  always_ff @(posedge convClk or negedge rst_n) begin
    if (!rst_n) begin
      l_r <= '0;
      l_r.oeMeta <= 1'b1;
      l_r.oeSync <= 1'b1;
      l_r.latchInv <= 1'b1;
    end else begin
      l_r <= l_nxt;
    end
  end

  assign primary_bus_data = l_r.primary;
  assign primaryBusOe = l_r.primaryOe;
  assign second_bus_data = l_r.second;
  assign secondBusOe = l_r.secondOe;
  assign output_latch_clock = l_r.latch;
  assign outputLatchClockInv = l_r.latchInv;
  assign latchClockOe = l_r.latchOe;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence fullRate40;
    !l_r.modeSync.rate80 && !interleave;
  endsequence

  sequence halfRateCapture;
    l_r.modeSync.rate80 && !interleave && capture;
  endsequence

  sequence wordA;
    primary_bus_data == $past(sampleA) && output_latch_clock;
  endsequence

  sequence wordB;
    primary_bus_data == $past(sampleB, 2) && !output_latch_clock;
  endsequence

  sequence enabledPins;
    !l_r.oeSync && !l_r.pdSync;
  endsequence

  sequence aOnlyCapture;
    l_r.modeSync.aOnly && !l_r.modeSync.dualBus && capture;
  endsequence

  sequence dualCapture;
    l_r.modeSync.dualBus && capture;
  endsequence

  sequence mappedSetup;
    setup && (paddr == CTRL_OFS || paddr == GAIN_OFS || paddr == STATUS_OFS ||
      paddr == COUNT_OFS);
  endsequence

  sequence unmappedSetup;
    setup && paddr != CTRL_OFS && paddr != GAIN_OFS && paddr != STATUS_OFS &&
      paddr != COUNT_OFS;
  endsequence

  sequence ctrlWrite;
    access && pwrite && paddr == CTRL_OFS && !pslverr;
  endsequence

  AST_PRIMARY_FLOAT: assert property (@(posedge convClk) disable iff (!rst_n)
    l_r.pdSync |=> !primaryBusOe)
    else $error("primary bus driven during power-down");

  AST_SECOND_FLOAT: assert property (@(posedge convClk) disable iff (!rst_n)
    (!l_r.modeSync.dualBus || l_r.pdSync) |=> !secondBusOe)
    else $error("second bus driven outside dual-bus mode");

  AST_ENABLE_PIN: assert property (@(posedge convClk) disable iff (!rst_n)
    $rose(outputEnable_n) ##3 outputEnable_n |-> !primaryBusOe && !latchClockOe)
    else $error("outputs still driven with output enable high");

  AST_LATCH_PAIR: assert property (@(posedge convClk) disable iff (!rst_n)
    l_r.pdSync |=> !latchClockOe && outputLatchClockInv == !output_latch_clock)
    else $error("latch clocks wrong during power-down");

  AST_RATE40: assert property (@(posedge convClk) disable iff (!rst_n)
    fullRate40 |=> l_r.sampleTgl != $past(l_r.sampleTgl))
    else $error("sample missed at full clock rate");

  AST_RATE80: assert property (@(posedge convClk) disable iff (!rst_n)
    halfRateCapture ##1 l_r.modeSync.rate80 |=> l_r.sampleTgl == $past(l_r.sampleTgl))
    else $error("sample taken on consecutive edges at 80MHz");

  AST_INTERLEAVE: assert property (@(posedge convClk) disable iff (!rst_n)
    (interleave && !l_r.phase) ##1 interleave |-> wordA ##1 wordB)
    else $error("interleaved words out of order");

  AST_DUAL_B: assert property (@(posedge convClk) disable iff (!rst_n)
    (l_r.modeSync.dualBus && capture) |=> second_bus_data == $past(sampleB))
    else $error("channel B word missing on second bus");

  AST_APB_ONE_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
    setup |=> pready ##1 !pready)
    else $error("APB answer not exactly one access cycle");

  AST_GAIN_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    (access && pwrite && paddr == GAIN_OFS && !pslverr)
      |=> gainCodeA == $past(pwdata[4:0]) && gainCodeB == $past(pwdata[12:8]))
    else $error("gain code not taken from write");

  // ----------------------------------------------------------------
  // Register bus answers
  // ----------------------------------------------------------------
  AST_APB_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  AST_APB_OK_ANSWER: assert property (@(posedge clk) disable iff (!rst_n)
    mappedSetup |=> pready && !pslverr)
    else $error("mapped register answered with error");

  AST_APB_ERR_ANSWER: assert property (@(posedge clk) disable iff (!rst_n)
    unmappedSetup |=> pready && pslverr && prdata == 32'h0)
    else $error("unmapped register not refused");

  AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    ctrlWrite |=> b_r.mode.dualBus == $past(pwdata[CTRL_DUAL_BIT]) &&
      b_r.mode.aOnly == $past(pwdata[CTRL_AONLY_BIT]))
    else $error("output mode not taken from write");

  AST_CTRL_READ: assert property (@(posedge clk) disable iff (!rst_n)
    setup && paddr == CTRL_OFS |=> prdata[CTRL_RATE80_BIT] == b_r.mode.rate80)
    else $error("mode read back wrong");

  AST_GAIN_READ: assert property (@(posedge clk) disable iff (!rst_n)
    setup && paddr == GAIN_OFS |=> prdata[GAIN_A_LSB +: GAIN_W] == gainCodeA &&
      prdata[GAIN_B_LSB +: GAIN_W] == gainCodeB)
    else $error("gain codes read back wrong");

  AST_STATUS_READ: assert property (@(posedge clk) disable iff (!rst_n)
    setup && paddr == STATUS_OFS |=> prdata[STAT_PDWN_BIT] == $past(b_r.pdSync))
    else $error("power-down status read back wrong");

  AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    b_r.tglSync != b_r.tglSeen |=> b_r.sampleCount == $past(b_r.sampleCount) + 16'h0001)
    else $error("capture count did not advance");

  AST_ERR_NO_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    access && pwrite && pslverr |=> $stable(b_r.mode) && $stable(b_r.gainA))
    else $error("refused write changed a register");

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  AST_LATCH_TOGGLE: assert property (@(posedge convClk) disable iff (!rst_n)
    1'b1 |=> output_latch_clock != $past(output_latch_clock))
    else $error("latch clock did not toggle");

  AST_LATCH_INV: assert property (@(posedge convClk) disable iff (!rst_n)
    latchClockOe |-> outputLatchClockInv == !output_latch_clock)
    else $error("inverted latch clock not inverse");

  AST_OE_DRIVE: assert property (@(posedge convClk) disable iff (!rst_n)
    enabledPins |=> primaryBusOe && latchClockOe)
    else $error("outputs not driven while enabled");

  AST_OE_RELEASE: assert property (@(posedge convClk) disable iff (!rst_n)
    l_r.oeSync |=> !primaryBusOe && !secondBusOe && !latchClockOe)
    else $error("outputs driven with enable released");

  AST_SECOND_DRIVE: assert property (@(posedge convClk) disable iff (!rst_n)
    enabledPins ##0 l_r.modeSync.dualBus |=> secondBusOe)
    else $error("second bus not driven in dual-bus mode");

  AST_A_ONLY: assert property (@(posedge convClk) disable iff (!rst_n)
    aOnlyCapture |=> primary_bus_data == $past(sampleA))
    else $error("channel A word missing in single channel mode");

  AST_DUAL_PRIMARY: assert property (@(posedge convClk) disable iff (!rst_n)
    dualCapture |=> primary_bus_data == $past(sampleA))
    else $error("channel A word missing in dual-bus mode");

  AST_HOLD_80: assert property (@(posedge convClk) disable iff (!rst_n)
    halfRateCapture ##1 l_r.modeSync.rate80 |-> !capture)
    else $error("capture on the edge after a capture at 80MHz");

  AST_INTERLEAVE_B: assert property (@(posedge convClk) disable iff (!rst_n)
    (interleave && !l_r.phase) ##1 interleave |=> primary_bus_data == $past(l_r.holdB))
    else $error("held channel B word not shown");

endmodule // dual_adc_output_bus_control

// [testbench/adc_rx_model.sv]
// Receiver model that captures converter words from the output pins
`timescale 1ns/1ps
module adc_rx_model
  import adc_out_pkg::*;
(
  // Pins from the converter
  input wire logic convClk,
  input wire logic [WORD_W-1:0] primary_bus_data,
  input wire logic primaryBusOe,
  input wire logic [WORD_W-1:0] second_bus_data,
  input wire logic secondBusOe,
  input wire logic output_latch_clock,
  input wire logic outputLatchClockInv,
  input wire logic latchClockOe,
  // Captured words: last and previous primary, second, latch history
  output logic [WORD_W-1:0] prim,
  output logic [WORD_W-1:0] primPrev,
  output logic [WORD_W-1:0] sec,
  output logic [2:0] lat
);
  // Released pins read as high impedance
  wire [WORD_W-1:0] primWire = primaryBusOe ? primary_bus_data : 'z;
  wire [WORD_W-1:0] secWire = secondBusOe ? second_bus_data : 'z;
  wire latWire = latchClockOe ? output_latch_clock : 1'bz;
  wire latInvWire = latchClockOe ? outputLatchClockInv : 1'bz;
  always @(posedge convClk) begin
    prim <= primWire;
    primPrev <= prim;
    sec <= secWire;
    lat <= {lat[1], latWire, latInvWire};
  end
endmodule // adc_rx_model

// [testbench/dual_adc_output_bus_control_tb.sv]
// Self-checking bench for the dual converter output bus control
`timescale 1ns/1ps
module dual_adc_output_bus_control_tb
  import adc_out_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, convClk, outputEnable_n, powerDown;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, primaryBusOe, secondBusOe, latchClockOe;
  logic output_latch_clock, outputLatchClockInv;
  logic [WORD_W-1:0] sampleA, sampleB, primary_bus_data, second_bus_data, prim, primPrev, sec;
  logic [WORD_W-1:0] seedA;
  logic [GAIN_W-1:0] gainCodeA, gainCodeB, ga, gb;
  logic [2:0] lat;
  logic [2:0] modes [5] = '{3'b000, 3'b010, 3'b101, 3'b001, 3'b011};
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;

  dual_adc_output_bus_control i_dual_adc_output_bus_control (.clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .convClk, .sampleA, .sampleB,
    .outputEnable_n, .powerDown, .gainCodeA, .gainCodeB, .primary_bus_data, .primaryBusOe,
    .second_bus_data, .secondBusOe, .output_latch_clock, .outputLatchClockInv, .latchClockOe);
  adc_rx_model i_adc_rx_model (.convClk, .primary_bus_data, .primaryBusOe, .second_bus_data,
    .secondBusOe, .output_latch_clock, .outputLatchClockInv, .latchClockOe, .prim, .primPrev,
    .sec, .lat);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    convClk = 1'b0;
    #3.7;
    forever #6 convClk = ~convClk;
  end
  // Channel B always carries the inverse of channel A, which holds the seed in reset and advances each edge after
  always @(posedge convClk) begin
    if (!rst_n) begin
      sampleA <= seedA;
      sampleB <= ~seedA;
    end else begin
      sampleA <= sampleA + 10'h001;
      sampleB <= ~(sampleA + 10'h001);
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      results();
    end
  end

  task automatic results();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Answer is read mid-cycle, where it has settled before the closing edge
    @(negedge clk);
    while (pready !== 1'b1) @(negedge clk);
    rd = prdata;
    err = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic link_check(input logic [2:0] m);
    logic [WORD_W-1:0] d;
    int changes = 0;
    apb(1'b1, CTRL_OFS, {29'h0, m});
    repeat (8) @(posedge convClk);
    chk("primaryOe", 32'(primaryBusOe), 32'h1);
    chk("secondOe", 32'(secondBusOe), 32'(m[0]));
    for (int i = 0; i < 8; i++) begin
      @(posedge convClk);
      #1;
      d = prim - primPrev;
      changes += (d != 10'h000);
      chk("latchInv", 32'(lat[0] ^ lat[1]), 32'h1);
      chk("latchToggle", 32'(lat[1] ^ lat[2]), 32'h1);
      if (m[0]) chk("second", 32'(sec ^ prim), 32'h3ff);
      d = prim + primPrev;
      if (m == 3'b000) chk("pairWord", 32'(d), lat[1] ? 32'h001 : 32'h3ff);
      else if (!m[2]) chk("step", 32'(prim - primPrev), 32'h1);
    end
    if (m[2]) chk("captures", 32'(changes), 32'h4);
    $display("test mode %h done", m);
  endtask

  task automatic float_check(input logic [31:0] st);
    repeat (10) @(posedge convClk);
    chk("primaryOe", 32'(primaryBusOe), 32'h0);
    chk("secondOe", 32'(secondBusOe), 32'h0);
    chk("latchOe", 32'(latchClockOe), 32'h0);
    apb(1'b1, STATUS_OFS, 32'h3);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status", rd, st);
    $display("test float %h done", st);
  endtask

  initial begin
    void'($urandom(29));
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    outputEnable_n = 1'b0;
    powerDown = 1'b0;
    seedA = 10'($urandom);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    chk("gainReset", 32'(gainCodeA), 32'(GAIN_RESET));
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrlReset", rd, 32'(CTRL_RESET));
    apb(1'b0, 8'h10, 32'h0);
    chk("unmappedErr", 32'(err), 32'h1);
    chk("unmappedData", rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      ga = (i == 0) ? 5'h1f : 5'($urandom);
      gb = (i == 0) ? 5'h00 : 5'($urandom);
      apb(1'b1, GAIN_OFS, {19'h0, gb, 3'h0, ga});
      apb(1'b0, GAIN_OFS, 32'h0);
      chk("gainRead", rd, {19'h0, gb, 3'h0, ga});
      chk("gainA", 32'(gainCodeA), 32'(ga));
      chk("gainB", 32'(gainCodeB), 32'(gb));
    end
    $display("test gain done");
    foreach (modes[i]) link_check(modes[i]);
    @(posedge clk);
    powerDown <= 1'b1;
    float_check(32'h1);
    @(posedge clk);
    powerDown <= 1'b0;
    outputEnable_n <= 1'b1;
    float_check(32'h0);
    results();
  end
endmodule // dual_adc_output_bus_control_tb
